// *** rtl/bus_cmd_pkg.sv ***
// Overview of operation
// - After grant goes low, wait the grant-to-command delay before enabling commands.
// - When grant goes high, command drivers float at once, without a clock, except I/O drivers in I/O bus mode.
// - Early I/O write is low earlier than normal write, timed like reads.
// - Early memory write is low ahead of normal write, timed like reads.
// - Address latch strobe is active high; latches capture on its falling edge.
// - Qualifier low forces all commands, transceiver and peripheral enables inactive.
// - Transceiver enable is active high and enables the data transceivers.
// - Direction is high for writes, low for reads.
// - Interrupt acknowledge is active low and requests the vector.
// - Strap high selects I/O bus mode; strap low selects system bus mode.
// - I/O and memory read and write commands are all active low.
// - Shared output is cascade enable when strap low, peripheral enable when high.
// - Status inputs idle high; undriven inputs are held high by pull-ups.
// - Decode 000 ack, 001 I/O read, 100 and 101 memory read.
// - 010 both I/O writes, 110 both memory writes, 011 and 111 nothing.
// - In I/O bus mode, I/O commands and ack ignore grant and start at once.
// - In I/O bus mode, memory commands still wait for grant.
// - Address strobe pulses every cycle and latches status for halt decoding.
// - In system mode, cascade enable asserts before the second acknowledge cycle.
package bus_cmd_pkg;
    localparam logic [2:0] ST_IRQ_ACK = 3'h0;
    localparam logic [2:0] ST_IO_RD = 3'h1;
    localparam logic [2:0] ST_IO_WR = 3'h2;
    localparam logic [2:0] ST_HALT = 3'h3;
    localparam logic [2:0] ST_FETCH = 3'h4;
    localparam logic [2:0] ST_MEM_RD = 3'h5;
    localparam logic [2:0] ST_MEM_WR = 3'h6;
    localparam logic [2:0] ST_PASSIVE = 3'h7;
    // Clock period and grant-to-command least delay, in ns
    localparam int CLK_PERIOD_NS = 40;
    localparam int GRANT_DELAY_NS = 100;
    localparam int GRANT_DELAY_CYC_I = (GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] GRANT_DELAY_CYC = 4'(GRANT_DELAY_CYC_I);
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_ALE = 4'b0010,
        PH_CMD = 4'b0100,
        PH_HALT = 4'b1000
    } phase_t;
endpackage : bus_cmd_pkg

// *** rtl/bus_cmd_ctrl.sv ***
`timescale 1ns/1ps
module bus_cmd_ctrl (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Processor status and straps
    input wire logic [2:0] i_cpu_status_code,
    input wire logic i_io_bus_strap,
    input wire logic i_command_qualifier,
    input wire logic i_bus_grant_n,
    // Command outputs, active low, with three-state enables (low = driving)
    output logic o_mem_read_cmd_n,
    output logic o_mem_write_cmd_n,
    output logic o_early_mem_write_cmd_n,
    output logic o_io_read_cmd_n,
    output logic o_io_write_cmd_n,
    output logic o_early_io_write_cmd_n,
    output logic o_irq_ack_cmd_n,
    output logic o_mem_cmd_oe_n,
    output logic o_io_cmd_oe_n,
    // Control outputs
    output logic o_addr_latch_strobe,
    output logic o_transceiver_enable,
    output logic o_transfer_direction,
    output logic o_cascade_or_periph_enable,
    output logic o_halted
);
    bus_cmd_pkg::phase_t phase;
    bus_cmd_pkg::phase_t next_phase;
    logic [2:0] status_latch;
    logic [2:0] status_q;
    logic [3:0] grant_cnt;
    logic first_ack_seen;
    logic [6:0] cmd_q;
    logic late_q;
    logic ctrl_q;
    logic dir_q;
    logic mce_q;

    // Pin inputs treated synchronous; undriven-high modelled outside
    wire status_active = (i_cpu_status_code != bus_cmd_pkg::ST_PASSIVE);
    wire start_cycle = (status_q == bus_cmd_pkg::ST_PASSIVE) && status_active;
    wire lat_halt = (status_latch == bus_cmd_pkg::ST_HALT);
    wire grant_ok = (grant_cnt >= bus_cmd_pkg::GRANT_DELAY_CYC);
    wire lat_ack = (status_latch == bus_cmd_pkg::ST_IRQ_ACK);
    wire lat_io_rd = (status_latch == bus_cmd_pkg::ST_IO_RD);
    wire lat_io_wr = (status_latch == bus_cmd_pkg::ST_IO_WR);
    wire lat_mem_rd = (status_latch == bus_cmd_pkg::ST_FETCH)
        || (status_latch == bus_cmd_pkg::ST_MEM_RD);
    wire lat_mem_wr = (status_latch == bus_cmd_pkg::ST_MEM_WR);
    wire lat_io_any = lat_ack || lat_io_rd || lat_io_wr;
    // I/O-class commands bypass grant only in I/O bus mode
    wire io_allowed = i_io_bus_strap || grant_ok;
    wire mem_allowed = grant_ok;
    wire cycle_allowed = lat_io_any ? io_allowed : mem_allowed;
    wire in_cmd = (phase == bus_cmd_pkg::PH_CMD);
    wire qual = i_command_qualifier;

    // Command set: early and read strobes start at once, normal writes one cycle later
    wire [6:0] next_cmd;
    assign next_cmd[0] = lat_mem_rd;
    assign next_cmd[1] = lat_mem_wr && late_q;
    assign next_cmd[2] = lat_mem_wr;
    assign next_cmd[3] = lat_io_rd;
    assign next_cmd[4] = lat_io_wr && late_q;
    assign next_cmd[5] = lat_io_wr;
    assign next_cmd[6] = lat_ack;

    always_comb begin
        next_phase = phase;
        case (phase)
            bus_cmd_pkg::PH_IDLE: begin
                if (start_cycle) begin
                    next_phase = bus_cmd_pkg::PH_ALE;
                end
            end
            // Halt cycles get their strobe too, then park in the halt phase
            bus_cmd_pkg::PH_ALE: begin
                if (!status_active) begin
                    next_phase = bus_cmd_pkg::PH_IDLE;
                end else if (lat_halt) begin
                    next_phase = bus_cmd_pkg::PH_HALT;
                end else begin
                    next_phase = bus_cmd_pkg::PH_CMD;
                end
            end
            bus_cmd_pkg::PH_CMD, bus_cmd_pkg::PH_HALT: begin
                if (!status_active) begin
                    next_phase = bus_cmd_pkg::PH_IDLE;
                end
            end
            default: next_phase = bus_cmd_pkg::PH_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            phase <= bus_cmd_pkg::PH_IDLE;
            status_q <= 3'h7;
        end else begin
            phase <= next_phase;
            status_q <= i_cpu_status_code;
        end
    end

    // Status latched at each cycle start for halt and command decoding
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_latch <= 3'h7;
        end else if (start_cycle) begin
            status_latch <= i_cpu_status_code;
        end
    end

    // Counts cycles since grant went low; resets when grant is withdrawn
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            grant_cnt <= 4'h0;
        end else if (i_bus_grant_n) begin
            grant_cnt <= 4'h0;
        end else if (!grant_ok) begin
            grant_cnt <= grant_cnt + 4'h1;
        end
    end

    // First of two back-to-back acknowledge cycles is tracked for cascade enable
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            first_ack_seen <= 1'b0;
        end else if (start_cycle) begin
            first_ack_seen <= (i_cpu_status_code == bus_cmd_pkg::ST_IRQ_ACK)
                && !first_ack_seen;
        end
    end

    // Command and control registers; release when status returns passive, direction one clock later
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cmd_q <= 7'h00;
            late_q <= 1'b0;
            ctrl_q <= 1'b0;
            dir_q <= 1'b0;
            mce_q <= 1'b0;
        end else if (in_cmd && status_active && cycle_allowed) begin
            cmd_q <= next_cmd;
            late_q <= 1'b1;
            ctrl_q <= !lat_ack || !first_ack_seen;
            dir_q <= lat_io_wr || lat_mem_wr;
            mce_q <= 1'b0;
        end else begin
            cmd_q <= 7'h00;
            late_q <= 1'b0;
            ctrl_q <= 1'b0;
            dir_q <= in_cmd ? dir_q : 1'b0;
            // Cascade enable for one clock after the strobe of the first acknowledge cycle
            mce_q <= (phase == bus_cmd_pkg::PH_ALE) && lat_ack && first_ack_seen;
        end
    end

    // Gated, active-low command outputs
    assign o_mem_read_cmd_n = !(cmd_q[0] && qual);
    assign o_mem_write_cmd_n = !(cmd_q[1] && qual);
    assign o_early_mem_write_cmd_n = !(cmd_q[2] && qual);
    assign o_io_read_cmd_n = !(cmd_q[3] && qual);
    assign o_io_write_cmd_n = !(cmd_q[4] && qual);
    assign o_early_io_write_cmd_n = !(cmd_q[5] && qual);
    assign o_irq_ack_cmd_n = !(cmd_q[6] && qual);
    // Drivers float combinationally when grant is high, except I/O drivers in I/O bus mode
    assign o_mem_cmd_oe_n = i_bus_grant_n;
    assign o_io_cmd_oe_n = i_bus_grant_n && !i_io_bus_strap;

    // Strobe high for the cycle after status goes active; falling edge latches
    assign o_addr_latch_strobe = (phase == bus_cmd_pkg::PH_ALE);
    wire io_path = i_io_bus_strap && lat_io_any;
    assign o_transceiver_enable = ctrl_q && qual && !io_path;
    assign o_transfer_direction = dir_q;
    assign o_cascade_or_periph_enable = i_io_bus_strap ? (ctrl_q && qual && io_path)
        : mce_q;
    assign o_halted = (phase == bus_cmd_pkg::PH_HALT);
endmodule : bus_cmd_ctrl

// *** tb/bus_cmd_ctrl_assertions.sv ***
`timescale 1ns/1ps
module bus_cmd_ctrl_assertions (
    input wire logic i_sys_clk, i_rstn, i_io_bus_strap, i_command_qualifier, i_bus_grant_n,
    input wire logic [2:0] i_cpu_status_code,
    input wire logic o_mem_read_cmd_n, o_mem_write_cmd_n, o_early_mem_write_cmd_n,
    input wire logic o_io_read_cmd_n, o_io_write_cmd_n, o_early_io_write_cmd_n, o_irq_ack_cmd_n,
    input wire logic o_mem_cmd_oe_n, o_io_cmd_oe_n, o_addr_latch_strobe, o_transceiver_enable,
    input wire logic o_transfer_direction, o_cascade_or_periph_enable, o_halted
);
    wire logic [6:0] cmds = {o_mem_read_cmd_n, o_mem_write_cmd_n, o_early_mem_write_cmd_n,
        o_io_read_cmd_n, o_io_write_cmd_n, o_early_io_write_cmd_n, o_irq_ack_cmd_n};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    AST_QUAL: assert property (!i_command_qualifier |-> &cmds && !o_transceiver_enable
        && !(i_io_bus_strap && o_cascade_or_periph_enable)) else $error("qualifier leak");
    AST_MEM_OE: assert property (o_mem_cmd_oe_n == i_bus_grant_n) else $error("mem oe");
    AST_IO_OE: assert property (i_io_bus_strap |-> !o_io_cmd_oe_n) else $error("io oe");
    AST_STROBE: assert property ($rose(o_addr_latch_strobe) |=> !o_addr_latch_strobe)
        else $error("strobe width");
    AST_RELEASE: assert property (i_cpu_status_code == bus_cmd_pkg::ST_PASSIVE |=> &cmds)
        else $error("no release");
    AST_DIR_WR: assert property (!(o_mem_write_cmd_n && o_io_write_cmd_n) |-> o_transfer_direction)
        else $error("write dir");
    AST_DIR_RD: assert property (!(o_mem_read_cmd_n && o_io_read_cmd_n) |-> !o_transfer_direction)
        else $error("read dir");
    AST_EARLY_MEM: assert property ($fell(o_mem_write_cmd_n) |-> !$past(o_early_mem_write_cmd_n))
        else $error("mem early");
    AST_EARLY_IO: assert property ($fell(o_io_write_cmd_n) |-> !$past(o_early_io_write_cmd_n))
        else $error("io early");
    AST_GRANT: assert property ($fell(o_mem_read_cmd_n) |-> !i_bus_grant_n && !$past(i_bus_grant_n, 2))
        else $error("grant wait");
    AST_HALT: assert property (o_halted |-> &cmds) else $error("halt cmd");
endmodule : bus_cmd_ctrl_assertions
bind bus_cmd_ctrl bus_cmd_ctrl_assertions i_bus_cmd_ctrl_assertions (.*);

// *** tb/cpu_status_model.sv ***
`timescale 1ns/1ps
module cpu_status_model (
    input wire logic i_sys_clk,
    output logic [2:0] o_status
);
    initial o_status = 3'h7;
    task drive(input logic [2:0] code);
        @(posedge i_sys_clk);
        #2 o_status = code;
    endtask : drive
endmodule : cpu_status_model

// *** tb/bus_cmd_ctrl_test.sv ***
`timescale 1ns/1ps
module bus_cmd_ctrl_test;
    logic clk = 0, rstn = 0, strap = 0, qual = 1, grant_n = 0;
    logic mem_oe_n, io_oe_n, ale, te, dir, cpe, halted;
    logic [2:0] st;
    wire [6:0] cmds;
    int fails = 0, check_count = 0, cycles = 0;
    localparam logic [6:0] EXP [8] = '{7'h7e, 7'h77, 7'h79, 7'h7f, 7'h3f, 7'h3f, 7'h4f, 7'h7f};
    initial forever #20 clk = ~clk;
    cpu_status_model i_cpu_status_model (.i_sys_clk(clk), .o_status(st));
    bus_cmd_ctrl i_bus_cmd_ctrl (.i_sys_clk(clk), .i_rstn(rstn), .i_cpu_status_code(st),
        .i_io_bus_strap(strap), .i_command_qualifier(qual), .i_bus_grant_n(grant_n),
        .o_mem_read_cmd_n(cmds[6]), .o_mem_write_cmd_n(cmds[5]), .o_early_mem_write_cmd_n(cmds[4]),
        .o_io_read_cmd_n(cmds[3]), .o_io_write_cmd_n(cmds[2]), .o_early_io_write_cmd_n(cmds[1]),
        .o_irq_ack_cmd_n(cmds[0]), .o_mem_cmd_oe_n(mem_oe_n), .o_io_cmd_oe_n(io_oe_n),
        .o_addr_latch_strobe(ale), .o_transceiver_enable(te), .o_transfer_direction(dir),
        .o_cascade_or_periph_enable(cpe), .o_halted(halted));
    task check(input logic [6:0] seen, input logic [6:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // Start a cycle and sample once commands have settled
    task bus(input logic [2:0] code);
        i_cpu_status_model.drive(code);
        repeat (4) @(posedge clk);
        #2;
    endtask : bus
    task idle;
        i_cpu_status_model.drive(3'h7);
        repeat (2) @(posedge clk);
        #2 check(cmds, 7'h7f);
    endtask : idle
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #2 rstn = 1;
        for (int c = 0; c < 8; c++) begin
            bus(3'(c));
            check(cmds, EXP[c]);
            if (c != 3 && c != 7) check(7'(dir), 7'(c == 2 || c == 6));
            if (c == 3) check(7'(halted), 7'h01);
            idle();
        end
        i_cpu_status_model.drive(3'h3);
        @(posedge clk);
        #2 check(7'(ale), 7'h01);
        @(posedge clk);
        #2 check({5'h00, ale, halted}, 7'h01);
        idle();
        bus(3'h5);
        check(7'(te), 7'h01);
        qual = 0;
        #1 check({cmds[6:1], te}, 7'h7e);
        qual = 1;
        idle();
        strap = 1;
        grant_n = 1;
        bus(3'h1);
        check(cmds, 7'h77);
        check({4'h0, io_oe_n, cpe, mem_oe_n}, 7'h03);
        idle();
        bus(3'h5);
        check(cmds, 7'h7f);
        grant_n = 0;
        repeat (5) @(posedge clk);
        #2 check(cmds, 7'h3f);
        idle();
        end_of_test();
    end
endmodule : bus_cmd_ctrl_test
